// ---- hw/pic_pkg.sv ----
package pic_pkg;

    // ********************************************
    // channel layout
    // ********************************************
    localparam int NUM_CH = 71;
    localparam int CH_IDX_W = 7;
    localparam int GRP_W = 2;
    localparam int NUM_GRP = 4;
    localparam logic [7:0] VEC_BASE = 8'h10;

    // ********************************************
    // register byte addresses
    // ********************************************
    localparam logic [23:0] ADDR_VECTOR = 24'hFFFE00;
    localparam logic [23:0] ADDR_TRAP_STATUS = 24'hFFFE04;
    localparam logic [23:0] ADDR_TRAP_CONTROL = 24'hFFFE08;
    localparam logic [23:0] ADDR_ACTIVE0 = 24'hFFFE10;
    localparam logic [23:0] ADDR_ACTIVE1 = 24'hFFFE14;
    localparam logic [23:0] ADDR_ACTIVE2 = 24'hFFFE18;
    localparam logic [23:0] ADDR_ENABLE0 = 24'hFFFE20;
    localparam logic [23:0] ADDR_ENABLE1 = 24'hFFFE24;
    localparam logic [23:0] ADDR_ENABLE2 = 24'hFFFE28;
    localparam logic [23:0] ADDR_GRP_LOW0 = 24'hFFFE50;
    localparam logic [23:0] ADDR_GRP_HIGH0 = 24'hFFFE54;
    localparam logic [23:0] ADDR_GRP_LOW1 = 24'hFFFE58;
    localparam logic [23:0] ADDR_GRP_HIGH1 = 24'hFFFE5C;
    localparam logic [23:0] ADDR_GRP_LOW2 = 24'hFFFE60;
    localparam logic [23:0] ADDR_GRP_HIGH2 = 24'hFFFE64;

    // ********************************************
    // field positions
    // ********************************************
    localparam int TRAP_EN_BIT = 0;
    localparam int TRAP_PIN_BIT = 1;
    localparam int TRAP_LOCK_BIT = 2;
    localparam int TRAP_EXT_BIT = 0;

    // ********************************************
    // reset values
    // ********************************************
    localparam logic [7:0] RST_VECTOR = 8'h10;
    localparam logic [NUM_CH-1:0] RST_ENABLE = 71'h0;
    localparam logic [NUM_CH-1:0] RST_GROUP = 71'h0;

endpackage

// ---- hw/pic_find_top.sv ----
`timescale 1ns/1ps
module pic_find_top
    import pic_pkg::*;
#(
    parameter int WIDTH = NUM_CH,
    parameter int IDX_W = CH_IDX_W
)
(
    // candidates
    input wire logic [WIDTH-1:0] i_cand,
    // result
    output logic o_any,
    output logic [IDX_W-1:0] o_idx
);

    // ********************************************
    // highest set index wins
    // ********************************************
    always_comb
    begin
        o_any = 1'b0;
        o_idx = '0;
        for (int i = 0; i < WIDTH; i++)
        begin
            if (i_cand[i])
            begin
                o_any = 1'b1;
                o_idx = IDX_W'(i);
            end
        end
    end

endmodule // pic_find_top

// ---- hw/pic_trap_unit.sv ----
`timescale 1ns/1ps
module pic_trap_unit
    import pic_pkg::*;
(
    // clock and reset
    input wire logic i_clock,
    input wire logic i_reset,
    // pin
    input wire logic i_nmi_n,
    // software access
    input wire logic i_ctrl_wr,
    input wire logic i_wr_en,
    input wire logic i_wr_lock,
    input wire logic i_stat_rd,
    // state
    output logic o_trap,
    output logic o_pin,
    output logic o_en,
    output logic o_lock,
    output logic o_ext
);

    logic sync1_ff, sync2_ff, prev_ff;
    logic en_ff, lock_ff, ext_ff, trap_ff;
    logic nxt_en, nxt_lock, nxt_ext, nxt_trap;
    logic fall;

    // ********************************************
    // synchroniser and edge
    // ********************************************
    // idle high at reset so release never looks like an edge
    always_ff @(posedge i_clock)
    begin
        if (i_reset)
        begin
            sync1_ff <= 1'b1;
            sync2_ff <= 1'b1;
            prev_ff <= 1'b1;
        end
        else
        begin
            sync1_ff <= i_nmi_n;
            sync2_ff <= sync1_ff;
            prev_ff <= sync2_ff;
        end
    end

    assign fall = prev_ff & ~sync2_ff;

    // ********************************************
    // enables and status
    // ********************************************
    always_comb
    begin
        nxt_trap = fall & (en_ff | lock_ff);
        nxt_lock = lock_ff | (i_ctrl_wr & i_wr_lock);
        nxt_en = en_ff;
        if (i_ctrl_wr)
        begin
            if (!i_wr_en)
                nxt_en = 1'b0;
            else if (!ext_ff)
                nxt_en = 1'b1;
        end
        if (nxt_trap)
            nxt_en = 1'b0;
        nxt_ext = ext_ff;
        if (i_stat_rd)
            nxt_ext = 1'b0;
        if (nxt_trap)
            nxt_ext = 1'b1;
    end

    always_ff @(posedge i_clock)
    begin
        if (i_reset)
        begin
            en_ff <= 1'b0;
            lock_ff <= 1'b0;
            ext_ff <= 1'b0;
            trap_ff <= 1'b0;
        end
        else
        begin
            en_ff <= nxt_en;
            lock_ff <= nxt_lock;
            ext_ff <= nxt_ext;
            trap_ff <= nxt_trap;
        end
    end

    assign o_trap = trap_ff;
    assign o_pin = ~sync2_ff;
    assign o_en = en_ff;
    assign o_lock = lock_ff;
    assign o_ext = ext_ff;

endmodule // pic_trap_unit

// ---- hw/pic_top.sv ----
// What this block does
// - trap disabled after reset until enabled
// - lock bit keeps trap enabled until reset
// - one-shot bit allows one trap, then clears
// - channel requests are level sensitive
// - per-channel enable gates competing requests
// - vector is winning channel plus 10h
// - acknowledge read returns current vector byte
// - withdrawn request may yield vector 10h
// - channel 0 never asserted; 1 to 70 used
// - four groups, lower number ranks higher
// - group first, then highest channel number
// - group is high bit, low bit
// - trap pin synchronised, falling edge traps
// - vector register resets to 10h
// - trap status clears on reset and read
// - hardware clears one-shot; set needs status clear
`timescale 1ns/1ps
module pic_top
    import pic_pkg::*;
(
    // clock and reset
    input wire logic i_clock,
    input wire logic i_reset,
    // peripheral requests, bit 0 unused
    input wire logic [NUM_CH-1:0] i_irq,
    // external trap pin
    input wire logic i_nmi_n,
    // core register access
    input wire logic [23:0] i_addr,
    input wire logic i_rd,
    input wire logic i_wr,
    input wire logic [31:0] i_wdata,
    output logic [31:0] o_rdata,
    output logic o_rvalid,
    // to the core
    output logic o_irq,
    output logic o_nmi
);

    // ********************************************
    // declarations
    // ********************************************
    // programmable state
    logic [NUM_CH-1:0] enable_ff;
    logic [NUM_CH-1:0] nxt_enable;
    logic [NUM_CH-1:0] grp_low_ff;
    logic [NUM_CH-1:0] nxt_grp_low;
    logic [NUM_CH-1:0] grp_high_ff;
    logic [NUM_CH-1:0] nxt_grp_high;

    // ranked result and read port
    logic [7:0] vector_ff;
    logic [7:0] nxt_vector;
    logic irq_ff;
    logic nxt_irq;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic rvalid_ff;
    logic nxt_rvalid;

    // priority network
    logic [NUM_CH-1:0] active;
    logic [NUM_CH-1:0] pending;
    logic [NUM_CH-1:0] cand [NUM_GRP];
    logic [NUM_GRP-1:0] grp_any;
    logic [CH_IDX_W-1:0] grp_idx [NUM_GRP];
    logic [CH_IDX_W-1:0] win_idx;
    logic win_any;

    // trap unit view
    logic trap_ctrl_wr;
    logic trap_stat_rd;
    logic trap_en;
    logic trap_lock;
    logic trap_ext;
    logic trap_pin;
    logic trap_pulse;

    // ********************************************
    // request gating
    // ********************************************
    // levels are used as seen; a source that needs an edge latches it
    // itself, so nothing is held here once the source drops
    always_comb
    begin
        active = i_irq;
        active[0] = 1'b0;
        pending = active & enable_ff;
    end

    // ********************************************
    // group split
    // ********************************************
    // a channel falls in exactly one group, so the finders never overlap
    genvar g;
    generate
        for (g = 0; g < NUM_GRP; g++)
        begin : g_grp
            always_comb
            begin
                for (int c = 0; c < NUM_CH; c++)
                begin
                    cand[g][c] = pending[c] &
                        ({grp_high_ff[c], grp_low_ff[c]} ==
                         GRP_W'(g));
                end
            end

            pic_find_top #(
                .WIDTH(NUM_CH),
                .IDX_W(CH_IDX_W)
            ) u_find (
                .i_cand(cand[g]),
                .o_any(grp_any[g]),
                .o_idx(grp_idx[g])
            );
        end
    endgenerate

    // ********************************************
    // winner across groups
    // ********************************************
    // scan from group 3 down so the lowest busy group is left standing
    always_comb
    begin
        win_any = 1'b0;
        win_idx = '0;
        for (int k = NUM_GRP - 1; k >= 0; k--)
        begin
            if (grp_any[k])
            begin
                win_any = 1'b1;
                win_idx = grp_idx[k];
            end
        end
    end

    // ********************************************
    // vector and request output
    // ********************************************
    // registered so an acknowledge read never sees a half-settled rank
    // one cycle of latency buys a short path into the read mux
    always_comb
    begin
        if (win_any)
            nxt_vector = VEC_BASE + 8'(win_idx);
        else
            nxt_vector = VEC_BASE;
        nxt_irq = win_any;
    end

    always_ff @(posedge i_clock)
    begin
        if (i_reset)
        begin
            vector_ff <= RST_VECTOR;
            irq_ff <= 1'b0;
        end
        else
        begin
            vector_ff <= nxt_vector;
            irq_ff <= nxt_irq;
        end
    end

    // ********************************************
    // register writes
    // ********************************************
    always_comb
    begin
        nxt_enable = enable_ff;
        nxt_grp_low = grp_low_ff;
        nxt_grp_high = grp_high_ff;
        // writes land at the strobe edge; the rank follows one edge later
        // word 2 keeps bits 6:0 only; higher write bits are dropped
        if (i_wr)
        begin
            case (i_addr)
                ADDR_ENABLE0: nxt_enable[31:0] = i_wdata;
                ADDR_ENABLE1: nxt_enable[63:32] = i_wdata;
                ADDR_ENABLE2: nxt_enable[70:64] = i_wdata[6:0];
                ADDR_GRP_LOW0: nxt_grp_low[31:0] = i_wdata;
                ADDR_GRP_LOW1: nxt_grp_low[63:32] = i_wdata;
                ADDR_GRP_LOW2: nxt_grp_low[70:64] = i_wdata[6:0];
                ADDR_GRP_HIGH0: nxt_grp_high[31:0] = i_wdata;
                ADDR_GRP_HIGH1: nxt_grp_high[63:32] = i_wdata;
                ADDR_GRP_HIGH2: nxt_grp_high[70:64] = i_wdata[6:0];
                default:
                begin
                    nxt_enable = enable_ff;
                end
            endcase
        end
        // channel 0 has no source, keep its enable dead
        nxt_enable[0] = 1'b0;
    end

    always_ff @(posedge i_clock)
    begin
        if (i_reset)
        begin
            enable_ff <= RST_ENABLE;
            grp_low_ff <= RST_GROUP;
            grp_high_ff <= RST_GROUP;
        end
        else
        begin
            enable_ff <= nxt_enable;
            grp_low_ff <= nxt_grp_low;
            grp_high_ff <= nxt_grp_high;
        end
    end

    // ********************************************
    // trap unit
    // ********************************************
    // the trap unit sees raw write data; only this decode gates it
    assign trap_ctrl_wr = i_wr && (i_addr == ADDR_TRAP_CONTROL);
    assign trap_stat_rd = i_rd && (i_addr == ADDR_TRAP_STATUS);

    pic_trap_unit u_trap (
        .i_clock(i_clock),
        .i_reset(i_reset),
        .i_nmi_n(i_nmi_n),
        .i_ctrl_wr(trap_ctrl_wr),
        .i_wr_en(i_wdata[TRAP_EN_BIT]),
        .i_wr_lock(i_wdata[TRAP_LOCK_BIT]),
        .i_stat_rd(trap_stat_rd),
        .o_trap(trap_pulse),
        .o_pin(trap_pin),
        .o_en(trap_en),
        .o_lock(trap_lock),
        .o_ext(trap_ext)
    );

    // ********************************************
    // register reads
    // ********************************************
    // read data lands one cycle after the strobe; a read of the status
    // word returns the value before its clear takes effect
    // active words show raw levels with channel 0 forced low, not masked by the enables
    always_comb
    begin
        nxt_rdata = rdata_ff;
        nxt_rvalid = i_rd;
        if (i_rd)
        begin
            nxt_rdata = 32'h0;
            case (i_addr)
                ADDR_VECTOR: nxt_rdata[7:0] = vector_ff;
                ADDR_TRAP_STATUS: nxt_rdata[TRAP_EXT_BIT] = trap_ext;
                ADDR_TRAP_CONTROL:
                begin
                    nxt_rdata[TRAP_EN_BIT] = trap_en;
                    nxt_rdata[TRAP_PIN_BIT] = trap_pin;
                    nxt_rdata[TRAP_LOCK_BIT] = trap_lock;
                end
                ADDR_ACTIVE0: nxt_rdata = active[31:0];
                ADDR_ACTIVE1: nxt_rdata = active[63:32];
                ADDR_ACTIVE2: nxt_rdata[6:0] = active[70:64];
                ADDR_ENABLE0: nxt_rdata = enable_ff[31:0];
                ADDR_ENABLE1: nxt_rdata = enable_ff[63:32];
                ADDR_ENABLE2: nxt_rdata[6:0] = enable_ff[70:64];
                ADDR_GRP_LOW0: nxt_rdata = grp_low_ff[31:0];
                ADDR_GRP_LOW1: nxt_rdata = grp_low_ff[63:32];
                ADDR_GRP_LOW2: nxt_rdata[6:0] = grp_low_ff[70:64];
                ADDR_GRP_HIGH0: nxt_rdata = grp_high_ff[31:0];
                ADDR_GRP_HIGH1: nxt_rdata = grp_high_ff[63:32];
                ADDR_GRP_HIGH2: nxt_rdata[6:0] = grp_high_ff[70:64];
                default:
                begin
                    nxt_rdata = 32'h0;
                end
            endcase
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (i_reset)
        begin
            rdata_ff <= 32'h0;
            rvalid_ff <= 1'b0;
        end
        else
        begin
            rdata_ff <= nxt_rdata;
            rvalid_ff <= nxt_rvalid;
        end
    end

    // ********************************************
    // outputs
    // ********************************************
    // the core gates o_irq with its own global and nesting enables and
    // drops nesting on acknowledge; nothing here waits on that
    assign o_irq = irq_ff;
    assign o_nmi = trap_pulse;
    assign o_rdata = rdata_ff;
    assign o_rvalid = rvalid_ff;

endmodule // pic_top

// ---- bench/pic_core_model.sv ----
`timescale 1ns/1ps
// ****************************************
// core side: register bus and acknowledge
// ****************************************
module pic_core_model
    import pic_pkg::*;
(
    // clock
    input wire logic i_clock,
    // bus to the controller
    output logic [23:0] o_addr,
    output logic o_rd,
    output logic o_wr,
    output logic [31:0] o_wdata,
    input wire logic [31:0] i_rdata,
    input wire logic i_rvalid,
    // maskable request
    input wire logic i_irq
);
    logic e_bit;
    logic i_bit;
    int n_late;
    initial
    begin
        o_addr = 24'h0;
        o_rd = 1'b0;
        o_wr = 1'b0;
        o_wdata = 32'h0;
        e_bit = 1'b0;
        i_bit = 1'b0;
        n_late = 0;
    end
    // released lines show the inverse so stale values never pass
    task automatic read(input logic [23:0] a, input int n,
                        output logic [31:0] d);
        int k;
        @(posedge i_clock);
        o_rd <= 1'b1;
        o_addr <= a;
        repeat (n) @(posedge i_clock);
        o_rd <= 1'b0;
        o_addr <= ~a;
        k = 0;
        #1;
        while (i_rvalid !== 1'b1 && k < 4)
        begin
            @(posedge i_clock);
            #1;
            k++;
        end
        if (k == 4)
            n_late++;
        d = i_rdata;
    endtask
    task automatic write(input logic [23:0] a, input logic [31:0] d);
        @(posedge i_clock);
        o_wr <= 1'b1;
        o_addr <= a;
        o_wdata <= d;
        @(posedge i_clock);
        o_wr <= 1'b0;
        o_addr <= ~a;
        o_wdata <= ~d;
    endtask
    task automatic ack(output logic [31:0] v);
        v = 32'h0;
        if (e_bit && i_bit && i_irq)
        begin
            read(ADDR_VECTOR, 1, v);
            i_bit = 1'b0;
        end
    endtask
endmodule // pic_core_model

// ---- bench/pic_props.sv ----
`timescale 1ns/1ps
// ****************************************
// port checker
// ****************************************
module pic_props
    import pic_pkg::*;
(
    // clock and reset
    input wire logic i_clock,
    input wire logic i_reset,
    // watched ports
    input wire logic [NUM_CH-1:0] i_irq,
    input wire logic i_nmi_n,
    input wire logic [23:0] i_addr,
    input wire logic i_rd,
    input wire logic i_wr,
    input wire logic [31:0] i_wdata,
    input wire logic [31:0] o_rdata,
    input wire logic o_rvalid,
    input wire logic o_irq,
    input wire logic o_nmi
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_reset);
    logic rd_vec;
    logic rd_stat;
    assign rd_vec = i_rd && i_addr == ADDR_VECTOR;
    assign rd_stat = i_rd && i_addr == ADDR_TRAP_STATUS;
    chk_read_answer: assert property (i_rd |=> o_rvalid)
        else $error("read not answered");
    chk_answer_cause: assert property (o_rvalid |-> $past(i_rd))
        else $error("answer without read");
    chk_trap_pulse: assert property (o_nmi |=> !o_nmi)
        else $error("trap pulse too long");
    chk_trap_sync: assert property (o_nmi |-> $past(!i_nmi_n, 3))
        else $error("trap without low pin");
    chk_idle_quiet: assert property
        (i_irq[NUM_CH-1:1] == '0 |=> !o_irq)
        else $error("request with no channel");
    chk_vector_range: assert property
        (o_rvalid && $past(i_addr) == ADDR_VECTOR |->
            o_rdata >= 32'h10 && o_rdata <= 32'h56)
        else $error("vector out of range");
    chk_vector_idle: assert property
        (rd_vec && !o_irq |=> o_rdata == 32'h10)
        else $error("idle vector wrong");
    chk_status_clear: assert property
        (rd_stat ##1 (rd_stat && !o_nmi) |=> o_rdata == 32'h0)
        else $error("status not cleared by read");
    cover property (o_nmi);
    cover property (rd_vec && o_irq);
    cover property (rd_stat ##1 rd_stat);
endmodule // pic_props
bind pic_top pic_props u_props (.i_clock, .i_reset, .i_irq, .i_nmi_n,
    .i_addr, .i_rd, .i_wr, .i_wdata, .o_rdata, .o_rvalid, .o_irq, .o_nmi);

// ---- bench/tb_top.sv ----
`timescale 1ns/1ps
// ****************************************
// testbench
// ****************************************
module tb_top
    import pic_pkg::*;
;
    logic i_clock;
    logic i_reset;
    logic [NUM_CH-1:0] i_irq;
    logic i_nmi_n;
    logic [23:0] addr;
    logic rd;
    logic wr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic rvalid;
    logic irq_out;
    logic nmi_out;
    int n_mismatch = 0;
    int n_compared = 0;
    pic_top DUT (.i_clock(i_clock), .i_reset(i_reset), .i_irq(i_irq),
        .i_nmi_n(i_nmi_n), .i_addr(addr), .i_rd(rd), .i_wr(wr),
        .i_wdata(wdata), .o_rdata(rdata), .o_rvalid(rvalid),
        .o_irq(irq_out), .o_nmi(nmi_out));
    pic_core_model u_core (.i_clock(i_clock), .o_addr(addr), .o_rd(rd),
        .o_wr(wr), .o_wdata(wdata), .i_rdata(rdata), .i_rvalid(rvalid),
        .i_irq(irq_out));
    always #5 i_clock = ~i_clock;
    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic rchk(input logic [23:0] a, input logic [31:0] exp,
                        input string name);
        logic [31:0] d;
        u_core.read(a, 1, d);
        check(name, d, exp);
    endtask
    task automatic irq_set(input logic [NUM_CH-1:0] v);
        @(posedge i_clock);
        i_irq <= v;
        repeat (2) @(posedge i_clock);
        #1;
    endtask
    // pin stays low afterwards so the pin bit can be read meanwhile
    task automatic pin_fall(output logic got);
        got = 1'b0;
        @(posedge i_clock);
        i_nmi_n <= 1'b0;
        repeat (8)
        begin
            @(posedge i_clock);
            #1;
            if (nmi_out === 1'b1)
                got = 1'b1;
        end
    endtask
    task automatic pin_rise();
        @(posedge i_clock);
        i_nmi_n <= 1'b1;
        repeat (3) @(posedge i_clock);
    endtask
    task automatic stop_test();
        n_mismatch += u_core.n_late;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic t_reset();
        rchk(ADDR_VECTOR, 32'h10, "vector");
        rchk(ADDR_TRAP_CONTROL, 32'h0, "control");
        rchk(ADDR_TRAP_STATUS, 32'h0, "status");
        rchk(ADDR_ENABLE1, 32'h0, "enable1");
        rchk(ADDR_GRP_HIGH2, 32'h0, "group2");
        u_core.write(ADDR_VECTOR, 32'h3F);
        rchk(ADDR_VECTOR, 32'h10, "vector ro");
        rchk(24'hFFFE40, 32'h0, "unmapped");
    endtask
    task automatic t_mask();
        logic [31:0] v;
        irq_set(71'h20);
        check("irq off", {31'h0, irq_out}, 32'h0);
        u_core.write(ADDR_ENABLE0, 32'h20);
        irq_set(71'h20);
        check("irq on", {31'h0, irq_out}, 32'h1);
        rchk(ADDR_VECTOR, 32'h15, "vector ch5");
        u_core.e_bit = 1'b1;
        u_core.i_bit = 1'b1;
        u_core.ack(v);
        check("ack", v, 32'h15);
        u_core.ack(v);
        check("nested", v, 32'h0);
        u_core.write(ADDR_ENABLE0, 32'hFFFFFFFF);
        irq_set(71'h1);
        check("chan0", {31'h0, irq_out}, 32'h0);
        rchk(ADDR_ACTIVE0, 32'h0, "active0");
        irq_set(71'h0);
        rchk(ADDR_VECTOR, 32'h10, "withdrawn");
    endtask
    task automatic t_group();
        u_core.write(ADDR_ENABLE2, 32'h7F);
        u_core.write(ADDR_GRP_LOW0, 32'h3A);
        u_core.write(ADDR_GRP_HIGH0, 32'h22);
        irq_set(71'h7E);
        rchk(ADDR_VECTOR, 32'h16, "six");
        irq_set(71'h22);
        rchk(ADDR_VECTOR, 32'h15, "grp3");
        u_core.write(ADDR_GRP_LOW2, 32'h40);
        u_core.write(ADDR_GRP_HIGH2, 32'h40);
        irq_set({1'b1, 66'h0, 4'h4});
        rchk(ADDR_VECTOR, 32'h12, "grp over num");
        rchk(ADDR_ACTIVE2, 32'h40, "active2");
        irq_set({1'b1, 70'h0});
        rchk(ADDR_VECTOR, 32'h56, "ch70");
        u_core.write(ADDR_GRP_LOW2, 32'h0);
        u_core.write(ADDR_GRP_LOW0, 32'h3E);
        u_core.write(ADDR_GRP_HIGH0, 32'h26);
        irq_set({1'b1, 66'h0, 4'h4});
        rchk(ADDR_VECTOR, 32'h56, "grp2 over 3");
    endtask
    task automatic t_trap();
        logic got;
        logic [31:0] d;
        pin_fall(got);
        check("trap off", {31'h0, got}, 32'h0);
        rchk(ADDR_TRAP_CONTROL, 32'h2, "pin");
        rchk(ADDR_TRAP_STATUS, 32'h0, "no ext");
        pin_rise();
        u_core.write(ADDR_TRAP_CONTROL, 32'h1);
        pin_fall(got);
        check("one shot", {31'h0, got}, 32'h1);
        rchk(ADDR_TRAP_CONTROL, 32'h2, "en cleared");
        u_core.write(ADDR_TRAP_CONTROL, 32'h1);
        rchk(ADDR_TRAP_CONTROL, 32'h2, "en refused");
        pin_rise();
        rchk(ADDR_TRAP_STATUS, 32'h1, "ext");
        u_core.read(ADDR_TRAP_STATUS, 2, d);
        check("ext cleared", d, 32'h0);
        pin_fall(got);
        check("after shot", {31'h0, got}, 32'h0);
        pin_rise();
        u_core.write(ADDR_TRAP_CONTROL, 32'h4);
        repeat (2)
        begin
            pin_fall(got);
            check("locked", {31'h0, got}, 32'h1);
            pin_rise();
        end
        u_core.write(ADDR_TRAP_CONTROL, 32'h0);
        rchk(ADDR_TRAP_CONTROL, 32'h4, "lock kept");
        @(posedge i_clock);
        i_reset <= 1'b1;
        repeat (2) @(posedge i_clock);
        i_reset <= 1'b0;
        rchk(ADDR_TRAP_CONTROL, 32'h0, "lock reset");
        rchk(ADDR_TRAP_STATUS, 32'h0, "ext reset");
    endtask
    initial
    begin
        i_clock = 1'b0;
        i_reset = 1'b1;
        i_irq = '0;
        i_nmi_n = 1'b1;
        repeat (2) @(posedge i_clock);
        i_reset <= 1'b0;
        t_reset();
        t_mask();
        t_group();
        t_trap();
        stop_test();
    end
endmodule // tb_top
